// ---- inc/poca_regs.svh ----
// Constants of the programmable output cell array: config offsets,
// reset values and the product term map.
// Assumes an 8-bit config register window that is selected elsewhere.
`ifndef POCA_REGS_SVH
`define POCA_REGS_SVH
// ----------------------------------------------------------------------
// Config register offsets within the window.
// ----------------------------------------------------------------------
`define POCA_OFS_GRP1 8'h20
`define POCA_OFS_GRP2 8'h21
`define POCA_OFS_MSK1 8'h22
`define POCA_OFS_MSK2 8'h23
`define POCA_OFS_INA 8'h24
`define POCA_OFS_INB 8'h25
`define POCA_OFS_INC 8'h26
`define POCA_MSK_RST 8'h00
// ----------------------------------------------------------------------
// Array sizes and the product term map.
// ----------------------------------------------------------------------
`define POCA_NUM_PT 137
`define POCA_NUM_IN 73
`define POCA_NUM_CELLS 16
`define POCA_GRP 8
`define POCA_NAT1 3
`define POCA_NAT2 4
`define POCA_NAT2_BASE 24
`define POCA_CS_BASE 56
`define POCA_NUM_CS 3
`define POCA_CTL_BASE 59
`define POCA_CTL_PER 4
`define POCA_POOL_BASE 123
`define POCA_POOL_SIZE 14
`define POCA_CAP1 6
`define POCA_CAP2_LO 5
`define POCA_CAP2_HI 6
`endif

// ---- inc/poca_pkg.sv ----
// Types shared by the output cell array files.
// Assumes nothing of its surroundings.
package poca_pkg;
  // Flip-flop behaviour of one output cell.
  typedef enum logic [1:0] {poca_ff_d, poca_ff_t, poca_ff_jk, poca_ff_sr} poca_ff_type;
endpackage : poca_pkg

// ---- hdl/poca_sync.sv ----
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
module poca_sync #(parameter int W = 1) (
  // Clock and reset.
  input logic i_core_clk,
  input logic i_rst_b,
  // Asynchronous input and its copy in the core domain.
  input logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } poca_sync_type;
  poca_sync_type state_r;
  poca_sync_type state_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    state_nxt.meta = i_async;
    state_nxt.sync = state_r.meta;
  end

  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_sync = state_r.sync;
endmodule : poca_sync

// ---- hdl/poca_cell.sv ----
// One output cell: polarity stage, configurable flip-flop and output select.
// Assumes product terms arrive registered in the core clock domain.
`timescale 1ns/1ps
module poca_cell (
  // Clock and reset.
  input logic i_core_clk,
  input logic i_rst_b,
  // Configuration.
  input logic i_pol,
  input logic i_use_ff,
  input poca_pkg::poca_ff_type i_ff_type,
  input logic i_clk_ext,
  // Product terms and clock events.
  input logic i_set,
  input logic i_rst,
  input logic i_clk_pt,
  input logic i_preset,
  input logic i_clear,
  input logic i_ext_rise,
  // Load from the data bus.
  input logic i_load,
  input logic i_load_data,
  // Cell outputs.
  output logic o_q,
  output logic o_out
);
  typedef struct packed {
    logic q;
    logic clk_prev;
  } poca_cell_type;
  poca_cell_type state_r;
  poca_cell_type state_nxt;

  // Flip-flop next state; a bus load overrides clock, preset and clear.
  always_comb begin
    logic tick;
    logic d;
    tick = 1'b0;
    d = 1'b0;
    state_nxt = state_r;
    state_nxt.clk_prev = i_clk_pt;
    tick = i_clk_ext ? i_ext_rise : (i_clk_pt & ~state_r.clk_prev);
    d = i_set ^ i_pol;
    if (i_load) begin
      state_nxt.q = i_load_data;
    end else if (i_clear) begin
      state_nxt.q = 1'b0;
    end else if (i_preset) begin
      state_nxt.q = 1'b1;
    end else if (tick) begin
      case (i_ff_type)
        poca_pkg::poca_ff_d: begin
          state_nxt.q = d;
        end
        poca_pkg::poca_ff_t: begin
          state_nxt.q = state_r.q ^ d;
        end
        poca_pkg::poca_ff_jk: begin
          if (d && i_rst) begin
            state_nxt.q = ~state_r.q;
          end else if (d) begin
            state_nxt.q = 1'b1;
          end else if (i_rst) begin
            state_nxt.q = 1'b0;
          end
        end
        default: begin
          // Reset wins when both set and reset are high.
          if (i_rst) begin
            state_nxt.q = 1'b0;
          end else if (d) begin
            state_nxt.q = 1'b1;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Output select between flip-flop and combinational path.
  assign o_q = state_r.q;
  assign o_out = i_use_ff ? state_r.q : (i_set ^ i_pol);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_load_wins;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_load |=> o_q == $past(i_load_data);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("bus load did not win");

  property p_clear;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_load && i_clear |=> !o_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear");

  property p_d_tick;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_clk_ext && $rose(i_clk_pt) && i_ff_type == poca_pkg::poca_ff_d && !i_load && !i_clear && !i_preset
      |=> o_q == $past(i_set ^ i_pol);
  endproperty
  a_d_tick: assert property (p_d_tick) else $error("D cell missed rising clock");

  property p_comb_path;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_use_ff |-> o_out == (i_set ^ i_pol);
  endproperty
  a_comb_path: assert property (p_comb_path) else $error("combinational path wrong");
endmodule : poca_cell

// ---- hdl/poca_array.sv ----
// Output cell array of the general logic array: AND array, term allocator,
// sixteen output cells, config registers and port pin drive.
// Assumes the config window select and address come from the MCU pins and
// that fuse inputs are static while the block runs.
`timescale 1ns/1ps
`include "poca_regs.svh"
module poca_array (
  // Clock and reset.
  input logic i_core_clk,
  input logic i_rst_b,
  // MCU bus pins; cntl bit 0 is the write strobe, bit 1 the read strobe, both low.
  input logic [2:0] i_cntl,
  input logic [15:0] i_addr,
  input logic i_cfg_sel,
  input logic [7:0] i_mcu_data,
  output logic [7:0] o_mcu_data,
  output logic o_mcu_data_oe,
  // Port pins.
  input logic [7:0] i_port_a,
  input logic [7:0] i_port_b,
  input logic [7:0] i_port_c,
  input logic [2:0] i_port_d,
  input logic i_ext_clk,
  output logic [7:0] o_port_a,
  output logic [7:0] o_port_a_oe,
  output logic [7:0] o_port_b,
  output logic [7:0] o_port_b_oe,
  output logic [7:0] o_port_c,
  output logic [7:0] o_port_c_oe,
  output logic [2:0] o_port_d_cs,
  // On-chip inputs in the core clock domain.
  input logic i_pdn,
  input logic i_rdy_busy,
  input logic [7:0] i_page,
  input logic [7:0] i_dir_a,
  input logic [7:0] i_dir_b,
  input logic [7:0] i_dir_c,
  // Fuse configuration.
  input logic [`POCA_NUM_PT-1:0][`POCA_NUM_IN-1:0] i_and_true,
  input logic [`POCA_NUM_PT-1:0][`POCA_NUM_IN-1:0] i_and_comp,
  input logic [15:0] i_cell_pol,
  input logic [15:0] i_cell_use_ff,
  input logic [15:0][1:0] i_cell_ff_type,
  input logic [15:0] i_cell_clk_ext,
  input logic [15:0] i_cell_expand,
  input logic [15:0][7:0] i_cell_borrow,
  input logic [15:0][3:0] i_cell_clr2,
  input logic [7:0] i_grp1_to_b,
  input logic [7:0] i_grp2_to_c,
  input logic i_load_level
);
  // ----------------------------------------------------------------------
  // State and helper functions
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`POCA_NUM_PT-1:0] pt;
    logic [15:0] expv;
    logic [7:0] msk1;
    logic [7:0] msk2;
    logic wr_prev_b;
    logic ext_prev;
    logic in_rst;
    logic [7:0] pa;
    logic [7:0] pa_oe;
    logic [7:0] pb;
    logic [7:0] pb_oe;
    logic [7:0] pc;
    logic [7:0] pc_oe;
    logic [2:0] cs;
    logic [7:0] rd;
    logic rd_oe;
  } poca_array_type;
  poca_array_type state_r;
  poca_array_type state_nxt;
  function automatic int nat_cnt(input int c);
    return (c < `POCA_GRP) ? `POCA_NAT1 : `POCA_NAT2;
  endfunction : nat_cnt
  function automatic int nat_idx(input int c, input int k);
    return (c < `POCA_GRP) ? c * `POCA_NAT1 + k : `POCA_NAT2_BASE + (c - `POCA_GRP) * `POCA_NAT2 + k;
  endfunction : nat_idx
  function automatic int cap(input int c);
    return (c < `POCA_GRP) ? `POCA_CAP1 : ((c < `POCA_GRP + 4) ? `POCA_CAP2_LO : `POCA_CAP2_HI);
  endfunction : cap
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [15:0] addr_s;
  logic [2:0] cntl_s;
  logic cfg_sel_s;
  logic [7:0] data_s;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic [2:0] pd_s;
  logic ext_s;
  poca_sync #(.W(56)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_ext_clk, i_port_d, i_port_c, i_port_b, i_port_a, i_mcu_data, i_cfg_sel, i_cntl, i_addr}),
    .o_sync({ext_s, pd_s, pc_s, pb_s, pa_s, data_s, cfg_sel_s, cntl_s, addr_s})
  );
  // ----------------------------------------------------------------------
  // Write strobe and load decode
  // ----------------------------------------------------------------------
  logic strobe;
  logic hit1;
  logic hit2;
  logic [15:0] ld;
  logic [15:0] cq;
  logic [15:0] cout;
  logic [`POCA_NUM_IN-1:0] inb;
  // Level loading repeats every cycle the strobe is low; edge loading fires once.
  assign strobe = i_load_level ? (cfg_sel_s & ~cntl_s[0]) : (cfg_sel_s & cntl_s[0] & ~state_r.wr_prev_b);
  assign hit1 = strobe && addr_s[7:0] == `POCA_OFS_GRP1;
  assign hit2 = strobe && addr_s[7:0] == `POCA_OFS_GRP2;
  assign ld[7:0] = hit1 ? ~state_r.msk1 : 8'h00;
  assign ld[15:8] = hit2 ? ~state_r.msk2 : 8'h00;
  // AND array input bus, with both cell groups fed back.
  assign inb = {i_rdy_busy, cout[15:8], cout[7:0], i_page, pd_s, pc_s, pb_s, pa_s,
                i_pdn, state_r.in_rst, cntl_s, addr_s};
  // ----------------------------------------------------------------------
  // Product term allocator
  // ----------------------------------------------------------------------
  logic [15:0][`POCA_NUM_PT-1:0] use_v;
  logic [15:0] rst_t;
  logic [15:0] sum_set;
  logic ovl;
  // Borrowing runs in ascending cell order, so a lower cell wins a contested term.
  always_comb begin
    int nb;
    int k;
    int ix;
    int cnt;
    logic [`POCA_NUM_PT-1:0] taken;
    logic [`POCA_NUM_PT-1:0] acc;
    logic two;
    nb = 0;
    k = 0;
    ix = 0;
    cnt = 0;
    taken = '0;
    acc = '0;
    two = 1'b0;
    use_v = '0;
    rst_t = '0;
    sum_set = '0;
    ovl = 1'b0;
    for (int c = 0; c < `POCA_NUM_CELLS; c++) begin
      cnt = 0;
      for (int b = 0; b < 8; b++) begin
        nb = (b < 4) ? c - 1 : c + 1;
        k = b % 4;
        if (i_cell_borrow[c][b] && nb >= 0 && nb < `POCA_NUM_CELLS && (nb / `POCA_GRP) == (c / `POCA_GRP)
            && k < nat_cnt(nb)) begin
          ix = nat_idx(nb, k);
          if (!taken[ix] && cnt < cap(c)) begin
            taken[ix] = 1'b1;
            use_v[c][ix] = 1'b1;
            cnt = cnt + 1;
          end
        end
      end
    end
    // Native terms not lent out stay with their owner.
    for (int c = 0; c < `POCA_NUM_CELLS; c++) begin
      two = i_cell_ff_type[c][1];
      for (int j = 0; j < `POCA_NAT2; j++) begin
        if (j < nat_cnt(c)) begin
          ix = nat_idx(c, j);
          if (!taken[ix] && two && j == 0) begin
            rst_t[c] = state_r.pt[ix];
          end else if (!taken[ix]) begin
            use_v[c][ix] = 1'b1;
          end
        end
      end
      if (two && !taken[nat_idx(c, 0)]) begin
        acc[nat_idx(c, 0)] = 1'b1;
      end
      if ((acc & use_v[c]) != '0) begin
        ovl = 1'b1;
      end
      acc = acc | use_v[c];
      // Expansion ORs in the neighbour's registered sum, costing one cycle.
      sum_set[c] = (|(use_v[c] & state_r.pt)) | (i_cell_expand[c] & state_r.expv[c]);
    end
  end
  // ----------------------------------------------------------------------
  // Output cells
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < `POCA_NUM_CELLS; g++) begin : g_cell
    logic clr;
    // Second clear term comes from the shared pool when selected.
    assign clr = state_r.pt[`POCA_CTL_BASE + g * `POCA_CTL_PER + 2]
               | (i_cell_clr2[g] < `POCA_POOL_SIZE && state_r.pt[`POCA_POOL_BASE + i_cell_clr2[g]]);
    poca_cell u_cell (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_pol(i_cell_pol[g]),
      .i_use_ff(i_cell_use_ff[g]),
      .i_ff_type(poca_pkg::poca_ff_type'(i_cell_ff_type[g])),
      .i_clk_ext(i_cell_clk_ext[g]),
      .i_set(sum_set[g]),
      .i_rst(rst_t[g]),
      .i_clk_pt(state_r.pt[`POCA_CTL_BASE + g * `POCA_CTL_PER]),
      .i_preset(state_r.pt[`POCA_CTL_BASE + g * `POCA_CTL_PER + 1]),
      .i_clear(clr),
      .i_ext_rise(ext_s & ~state_r.ext_prev),
      .i_load(ld[g]),
      .i_load_data(data_s[g % `POCA_GRP]),
      .o_q(cq[g]),
      .o_out(cout[g])
    );
  end
  // ----------------------------------------------------------------------
  // Next state: AND array, registers, readback and pins
  // ----------------------------------------------------------------------
  always_comb begin
    logic ctl_oe;
    ctl_oe = 1'b0;
    state_nxt = state_r;
    state_nxt.in_rst = 1'b0;
    state_nxt.wr_prev_b = cntl_s[0];
    state_nxt.ext_prev = ext_s;
    // A term with no literals selected reads as one.
    for (int p = 0; p < `POCA_NUM_PT; p++) begin
      state_nxt.pt[p] = (&(~i_and_true[p] | inb)) & (&(~i_and_comp[p] | ~inb));
    end
    for (int c = 0; c < `POCA_NUM_CELLS; c++) begin
      state_nxt.expv[c] = (c % `POCA_GRP != `POCA_GRP - 1) ? sum_set[(c + 1) % `POCA_NUM_CELLS] : 1'b0;
    end
    // Mask writes share the load strobe.
    if (strobe && addr_s[7:0] == `POCA_OFS_MSK1) begin
      state_nxt.msk1 = data_s;
    end else if (strobe && addr_s[7:0] == `POCA_OFS_MSK2) begin
      state_nxt.msk2 = data_s;
    end
    // Readback; offsets outside this block leave the bus undriven for others.
    state_nxt.rd = 8'h00;
    state_nxt.rd_oe = 1'b0;
    if (cfg_sel_s && !cntl_s[1]) begin
      state_nxt.rd_oe = 1'b1;
      if (addr_s[7:0] == `POCA_OFS_GRP1) begin
        state_nxt.rd = cq[7:0];
      end else if (addr_s[7:0] == `POCA_OFS_GRP2) begin
        state_nxt.rd = cq[15:8];
      end else if (addr_s[7:0] == `POCA_OFS_MSK1) begin
        state_nxt.rd = state_r.msk1;
      end else if (addr_s[7:0] == `POCA_OFS_MSK2) begin
        state_nxt.rd = state_r.msk2;
      end else if (addr_s[7:0] == `POCA_OFS_INA) begin
        state_nxt.rd = pa_s;
      end else if (addr_s[7:0] == `POCA_OFS_INB) begin
        state_nxt.rd = pb_s;
      end else if (addr_s[7:0] == `POCA_OFS_INC) begin
        state_nxt.rd = pc_s;
      end else begin
        state_nxt.rd_oe = 1'b0;
      end
    end
    // Pin routing; group two wins a port B pin claimed by both groups.
    {state_nxt.pa, state_nxt.pa_oe, state_nxt.pb, state_nxt.pb_oe, state_nxt.pc, state_nxt.pc_oe} = 48'h0;
    for (int n = 0; n < `POCA_GRP; n++) begin
      ctl_oe = state_r.pt[`POCA_CTL_BASE + n * `POCA_CTL_PER + 3];
      if (!i_grp1_to_b[n]) begin
        state_nxt.pa[n] = cout[n];
        state_nxt.pa_oe[n] = ctl_oe | i_dir_a[n];
      end else begin
        state_nxt.pb[n] = cout[n];
        state_nxt.pb_oe[n] = ctl_oe | i_dir_b[n];
      end
      ctl_oe = state_r.pt[`POCA_CTL_BASE + (n + `POCA_GRP) * `POCA_CTL_PER + 3];
      if (!i_grp2_to_c[n]) begin
        state_nxt.pb[n] = cout[n + `POCA_GRP];
        state_nxt.pb_oe[n] = ctl_oe | i_dir_b[n];
      end else begin
        state_nxt.pc[n] = cout[n + `POCA_GRP];
        state_nxt.pc_oe[n] = ctl_oe | i_dir_c[n];
      end
    end
    state_nxt.cs = state_r.pt[`POCA_CS_BASE +: `POCA_NUM_CS];
  end
  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= '0;
      state_r.in_rst <= 1'b1;
      state_r.wr_prev_b <= 1'b1;
      state_r.msk1 <= `POCA_MSK_RST;
      state_r.msk2 <= `POCA_MSK_RST;
    end else begin
      state_r <= state_nxt;
    end
  end
  // Outputs straight from the state register.
  assign o_mcu_data = state_r.rd;
  assign o_mcu_data_oe = state_r.rd_oe;
  assign o_port_a = state_r.pa;
  assign o_port_a_oe = state_r.pa_oe;
  assign o_port_b = state_r.pb;
  assign o_port_b_oe = state_r.pb_oe;
  assign o_port_c = state_r.pc;
  assign o_port_c_oe = state_r.pc_oe;
  assign o_port_d_cs = state_r.cs;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_edge_load;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_load_level && ld[0] |=> cq[0] == $past(data_s[0]);
  endproperty
  a_edge_load: assert property (p_edge_load) else $error("edge load lost");
  property p_level_load;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_load_level && ld[9] |=> cq[9] == $past(data_s[1]);
  endproperty
  a_level_load: assert property (p_level_load) else $error("level load lost");
  property p_mask_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    strobe && addr_s[7:0] == `POCA_OFS_MSK1 |=> state_r.msk1 == $past(data_s);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");
  property p_read_back;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    cfg_sel_s && !cntl_s[1] && addr_s[7:0] == `POCA_OFS_GRP2 |=> o_mcu_data_oe && o_mcu_data == $past(cq[15:8]);
  endproperty
  a_read_back: assert property (p_read_back) else $error("readback wrong");
  property p_chip_sel;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    1'b1 |=> o_port_d_cs == $past(state_r.pt[`POCA_CS_BASE +: `POCA_NUM_CS]);
  endproperty
  a_chip_sel: assert property (p_chip_sel) else $error("chip select wrong");
  property p_pin_oe;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_grp1_to_b[0] |=> o_port_a_oe[0] == $past(state_r.pt[`POCA_CTL_BASE + 3] | i_dir_a[0]);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  property p_exclusive;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !ovl;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("term given twice");
  c_edge_load: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) !i_load_level && hit1);
  c_level_load: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) i_load_level && hit2 [*3]);
  c_masked: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) hit1 && state_r.msk1 == 8'h0F);
  c_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) o_mcu_data_oe);
endmodule : poca_array

// ---- verification/poca_mcu_model.sv ----
// MCU bus model that drives the config window pins of the output cell array.
// Assumes the bench calls acc from one process, one access at a time.
`timescale 1ns/1ps
module poca_mcu_model (
  // Clock.
  input logic i_core_clk,
  // Bus pins toward the array.
  output logic [2:0] o_cntl,
  output logic [15:0] o_addr,
  output logic o_cfg_sel,
  output logic [7:0] o_data
);
  // Idle bus: both strobes high and the window deselected.
  initial begin
    o_cntl = 3'h7;
    o_addr = 16'h0000;
    o_cfg_sel = 1'b0;
    o_data = 8'h00;
  end
  // The strobe stands four cycles so the pin synchroniser sees it, and the address
  // stands four more after release so an edge load still finds its offset.
  task automatic acc(input logic w, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= {8'h00, ofs};
    o_cfg_sel <= 1'b1;
    o_data <= d;
    o_cntl <= w ? 3'h6 : 3'h5;
    repeat (4) @(posedge i_core_clk);
    o_cntl <= 3'h7;
    repeat (4) @(posedge i_core_clk);
    // Released lines flip so a stale value never passes for a hold.
    o_cfg_sel <= 1'b0;
    o_addr <= ~o_addr;
    o_data <= ~o_data;
  endtask : acc
endmodule : poca_mcu_model

// ---- verification/poca_array_tb.sv ----
// Self-checking bench of the output cell array, with an MCU model on its bus.
// Assumes all product terms but the chip selects and cell zero's pin enable are fused off, so cells change only by bus loads.
`timescale 1ns/1ps
`include "poca_regs.svh"
module poca_array_tb;
  logic i_core_clk, i_rst_b, ld_lvl, oe_prev;
  logic [2:0] cntl;
  logic [15:0] addr;
  logic cfg_sel;
  logic [7:0] mdata, o_mcu_data, pa, pb, pc, d_a, d_b, d_c, o_port_a, o_port_b, o_port_c, g1b, g2c;
  logic [7:0] o_port_a_oe, o_port_b_oe, o_port_c_oe;
  logic [2:0] o_port_d_cs;
  logic [15:0] pol, uff, pv;
  logic o_mcu_data_oe, ext;
  logic [31:0] rnd = 32'h6A79;
  logic [7:0] c1, c2, k1, k2;
  logic [`POCA_NUM_PT-1:0][`POCA_NUM_IN-1:0] fz = '1;
  logic [7:0] exp_q[$];
  int fails = 0;
  int checks = 0;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  poca_mcu_model mcu_u (.i_core_clk(i_core_clk), .o_cntl(cntl), .o_addr(addr), .o_cfg_sel(cfg_sel), .o_data(mdata));
  // Every term holds a literal and its complement and reads zero, except the chip selects and
  // cell zero's pin enable, which hold no literal and read one.
  poca_array dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cntl(cntl), .i_addr(addr), .i_cfg_sel(cfg_sel),
    .i_mcu_data(mdata), .o_mcu_data(o_mcu_data), .o_mcu_data_oe(o_mcu_data_oe), .i_port_a(pa), .i_port_b(pb),
    .i_port_c(pc), .i_port_d(pa[2:0]), .i_ext_clk(ext), .o_port_a(o_port_a), .o_port_a_oe(o_port_a_oe),
    .o_port_b(o_port_b), .o_port_b_oe(o_port_b_oe), .o_port_c(o_port_c), .o_port_c_oe(o_port_c_oe),
    .o_port_d_cs(o_port_d_cs), .i_pdn(pb[0]), .i_rdy_busy(pc[0]), .i_page(pc), .i_dir_a(d_a), .i_dir_b(d_b),
    .i_dir_c(d_c), .i_and_true(fz), .i_and_comp(fz), .i_cell_pol(pol), .i_cell_use_ff(uff), .i_cell_ff_type('0),
    .i_cell_clk_ext(16'h0000), .i_cell_expand(16'h0000), .i_cell_borrow('0), .i_cell_clr2('1), .i_grp1_to_b(g1b),
    .i_grp2_to_c(g2c), .i_load_level(ld_lvl));
  // Pin inputs wander at random; no term can see them.
  always @(posedge i_core_clk) begin
    rnd <= lfsr_next(rnd);
    pa <= rnd[7:0];
    pb <= rnd[15:8];
    pc <= rnd[23:16];
    ext <= rnd[24];
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Pin routing: group two wins a shared port B pin; only cell zero has a live enable term.
  task automatic chk_pins(input logic [7:0] v1, input logic [7:0] v2);
    chk("port_a", v1 & ~g1b, o_port_a);
    chk("port_b", (v2 & ~g2c) | (v1 & g1b & g2c), o_port_b);
    chk("port_c", v2 & g2c, o_port_c);
    chk("port_a_oe", (d_a | 8'h01) & ~g1b, o_port_a_oe);
    chk("port_b_oe", (d_b & ~g2c) | ((d_b | 8'h01) & g1b & g2c), o_port_b_oe);
    chk("port_c_oe", d_c & g2c, o_port_c_oe);
    chk("port_d_cs", 8'h07, {5'h00, o_port_d_cs});
  endtask : chk_pins
  // Each rising read enable takes the oldest note; one with no note was never expected.
  always @(posedge i_core_clk) begin
    if (o_mcu_data_oe === 1'b1 && !oe_prev) begin
      if (exp_q.size() == 0) chk("read_oe", 8'h00, 8'h01);
      else chk("read_data", exp_q.pop_front(), o_mcu_data);
    end
    oe_prev <= (o_mcu_data_oe === 1'b1);
  end
  // Access with model update; masked cells keep their old bit.
  task automatic acc(input logic w, input logic [7:0] ofs, input logic [7:0] d);
    if (w) begin
      case (ofs)
        8'h20: c1 = (c1 & k1) | (d & ~k1);
        8'h21: c2 = (c2 & k2) | (d & ~k2);
        8'h22: k1 = d;
        8'h23: k2 = d;
        default: ;
      endcase
    end else if (ofs >= 8'h20 && ofs <= 8'h23) begin
      exp_q.push_back(ofs == 8'h20 ? c1 : ofs == 8'h21 ? c2 : ofs == 8'h22 ? k1 : k2);
    end
    mcu_u.acc(w, ofs, d);
  endtask : acc
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0 && exp_q.size() == 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    tally_and_finish;
  end
  // Both load methods, each after a fresh reset.
  initial begin
    i_rst_b = 1'b0;
    oe_prev = 1'b0;
    // Chip select terms and cell zero's enable term carry no literal, so they read one.
    for (int p = 0; p < `POCA_NUM_CS; p++) fz[`POCA_CS_BASE + p] = '0;
    fz[`POCA_CTL_BASE + 3] = '0;
    for (int m = 0; m < 2; m++) begin
      @(posedge i_core_clk);
      i_rst_b <= 1'b0;
      ld_lvl <= m[0];
      {d_a, d_b, d_c, pol, uff} <= {8'h5A, 8'hC3, 8'h96, 16'h0000, 16'hFFFF};
      g1b <= m[0] ? 8'h3C : 8'h00;
      g2c <= m[0] ? 8'h0F : 8'h00;
      repeat (6) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      {c1, c2, k1, k2} = '0;
      acc(0, 8'h22, 0);
      acc(0, 8'h23, 0);
      acc(1, 8'h20, rnd[7:0]);
      acc(1, 8'h21, rnd[15:8]);
      acc(0, 8'h20, 0);
      acc(0, 8'h21, 0);
      acc(1, 8'h22, 8'h0F);
      acc(1, 8'h23, 8'hF0);
      acc(1, 8'h20, ~c1);
      acc(1, 8'h21, ~c2);
      acc(0, 8'h20, 0);
      acc(0, 8'h21, 0);
      acc(0, 8'h23, 0);
      acc(1, 8'h2F, 8'hFF);
      acc(0, 8'h2F, 0);
      acc(0, 8'h20, 0);
      repeat (4) @(posedge i_core_clk);
      chk_pins(c1, c2);
      // Combinational bypass: with no term set, each cell shows its polarity bit.
      pv = rnd[15:0];
      pol <= pv;
      uff <= 16'h0000;
      repeat (2) @(posedge i_core_clk);
      chk_pins(pv[7:0], pv[15:8]);
    end
    tally_and_finish;
  end
endmodule : poca_array_tb
